// ---- hdl/nvm_array.sv ----
// byte-wide storage array, written on the cycle a byte completes
// assumes: the bus engine drives the ctrl side of the interface
`default_nettype none
module nvm_array
  import nvm_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  nvm_mem_if.array  mem
);
  logic [DATA_W-1:0] store [DEPTH];

  assign mem.rdata = store[mem.addr];

  always_ff @(posedge mclk) begin
    if (ce && mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
  end

  AST_WRITE_LANDS: assert property (
    @(posedge mclk) disable iff (rst)
    (ce && mem.we) |=> store[$past(mem.addr)] == $past(mem.wdata))
    else $error("written byte not in array next cycle");
endmodule // nvm_array
`default_nettype wire

// ---- hdl/nvm_i2c_slave.sv ----
// two-wire serial slave front end for a 16K x 8 byte memory
// assumes: scl/sda/straps/wp are pins sampled by mclk; sda is
// open drain and resolved outside from sdaOe
`default_nettype none
module nvm_i2c_slave
  import nvm_pkg::*;
#(
  parameter logic [15:0] ID_MFR_P  = ID_MFR,
  parameter logic [7:0]  ID_DENS_P = ID_DENS,
  parameter logic [7:0]  ID_REV_P  = ID_REV
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [2:0]  deviceSelectStraps,
  input  wire logic        wp,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  output logic             hsMode
);
  nvm_mem_if memIf ();
  logic [5:0]        pinS;
  logic [2:0]        strapS;
  logic [3:0]        bitCnt;
  logic [7:0]        shift;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       idValue;
  nvm_state_t        state;
  nvm_phase_t        phase;
  logic              sclS, sdaS, wpS, sclD, sdaD;
  logic              sclRise, sclFall, startEv, stopEv;
  logic              rdDir, mastAck, ctlEnable;
  logic              byteDone, devHit, mcodeHit, ackNow;
  logic              loadRd, wrNow, addrInc, addrLoad;
  // open-drain pins and straps cross in through two flops
  nvm_sync #(
    .W  (6),
    .RV (6'h03)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .din  ({wp, deviceSelectStraps, sdaIn, scl}),
    .dout (pinS)
  );

  assign sclS   = pinS[0];
  assign sdaS   = pinS[1];
  assign strapS = pinS[4:2]; // pulled-down pins arrive as 0
  assign wpS    = pinS[5];   // open pin arrives as 0

  nvm_array #(
    .DEPTH (MEM_DEPTH)
  ) u_array (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .mem  (memIf)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else if (ce) begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  // edges are only seen at mclk granularity
  assign sclRise = sclS && !sclD;
  assign sclFall = !sclS && sclD;
  assign startEv = sclS && sclD && sdaD && !sdaS;
  assign stopEv  = sclS && sclD && !sdaD && sdaS;

  assign byteDone = (state == ST_RX) && sclFall && (bitCnt == BYTE_BITS);
  assign devHit   = (phase == PH_DEV) && ctlEnable
                  && (shift[7:4] == DEV_TYPE)
                  && (shift[3:1] == strapS);
  assign mcodeHit = (phase == PH_DEV) && (shift[7:3] == MCODE_HS);
  assign ackNow   = byteDone && ((phase != PH_DEV) || devHit);
  assign loadRd   = sclFall
                  && (((state == ST_RXACK) && rdDir && (phase == PH_DEV))
                  || ((state == ST_TXACK) && mastAck));
  assign wrNow    = byteDone && (phase == PH_DATA) && !wpS;
  assign addrLoad = byteDone && ((phase == PH_HI) || (phase == PH_LO));
  assign addrInc  = (byteDone && (phase == PH_DATA)) || loadRd;

  assign memIf.we    = wrNow && !startEv && !stopEv;
  assign memIf.addr  = addr;
  assign memIf.wdata = shift;

  // bit and byte sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      state   <= ST_IDLE;
      phase   <= PH_DEV;
      bitCnt  <= 4'h0;
      rdDir   <= 1'b0;
      mastAck <= 1'b0;
    end else if (ce) begin
      if (startEv) begin
        state  <= ST_RX;
        phase  <= PH_DEV;
        bitCnt <= 4'h0;
      end else if (stopEv) begin
        state  <= ST_IDLE;
        phase  <= PH_DEV;
        bitCnt <= 4'h0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            bitCnt <= 4'h0;
          end
          ST_RX: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (byteDone) begin
              bitCnt <= 4'h0;
              if (ackNow) begin
                state <= ST_RXACK;
                if (phase == PH_DEV) begin
                  rdDir <= shift[0];
                end
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_RXACK: begin
            if (sclFall) begin
              if (loadRd) begin
                state  <= ST_TX;
                bitCnt <= 4'h1;
              end else begin
                state <= ST_RX;
                unique case (phase)
                  PH_DEV:  phase <= PH_HI;
                  PH_HI:   phase <= PH_LO;
                  PH_LO:   phase <= PH_DATA;
                  PH_DATA: phase <= PH_DATA;
                endcase
              end
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt == BYTE_BITS) begin
                state  <= ST_TXACK;
                bitCnt <= 4'h0;
              end else begin
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (sclRise) begin
              mastAck <= !sdaS;
            end else if (sclFall) begin
              if (mastAck) begin
                state  <= ST_TX;
                bitCnt <= 4'h1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // shift register: sample on rise, present read bytes on fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift <= 8'h00;
    end else if (ce) begin
      if ((state == ST_RX) && sclRise) begin
        shift <= {shift[6:0], sdaS};
      end else if (loadRd) begin
        shift <= memIf.rdata;
      end else if ((state == ST_TX) && sclFall) begin
        shift <= {shift[6:0], 1'b1};
      end
    end
  end

  // open-drain drive: only ever pull low, changed on scl fall, released on start or stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      sdaOe  <= 1'b0;
      sdaOut <= 1'b0;
    end else if (ce) begin
      sdaOut <= 1'b0;
      if (startEv || stopEv) begin
        sdaOe <= 1'b0;
      end else if (sclFall) begin
        if (ackNow) begin
          sdaOe <= 1'b1;
        end else if (loadRd) begin
          sdaOe <= !memIf.rdata[7];
        end else if ((state == ST_TX) && (bitCnt != BYTE_BITS)) begin
          sdaOe <= !shift[6];
        end else begin
          sdaOe <= 1'b0;
        end
      end
    end
  end

  // address latch: 14 bits, upper two sent bits dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr <= ADDR_FIRST;
    end else if (ce && !startEv && !stopEv) begin
      if (addrLoad && (phase == PH_HI)) begin
        addr[13:8] <= shift[5:0];
      end else if (addrLoad) begin
        addr[7:0] <= shift;
      end else if (addrInc) begin
        addr <= addr + 14'h1;
      end
    end
  end

  // high speed stays on until stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      hsMode <= 1'b0;
    end else if (ce) begin
      if (stopEv) begin
        hsMode <= 1'b0;
      end else if (byteDone && mcodeHit) begin
        hsMode <= 1'b1;
      end
    end
  end

  // register port
  assign idValue = {ID_MFR_P, ID_DENS_P, ID_REV_P};
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctlEnable <= CTRL_EN_RV;
    end else if (ce && regWr && (regAddr == OFS_CTRL)) begin
      ctlEnable <= regWrData[CTRL_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else if (ce) begin
      regRdData <= 32'h0000_0000;
      if (regRd) begin
        unique case (regAddr)
          OFS_ID:   regRdData <= idValue;
          OFS_CTRL: regRdData[CTRL_EN] <= ctlEnable;
          OFS_STAT: begin
            regRdData[STAT_HS]              <= hsMode;
            regRdData[STAT_BUSY]            <= state != ST_IDLE;
            regRdData[STAT_WP]              <= wpS;
            regRdData[STAT_SEL+2:STAT_SEL]  <= strapS;
          end
          default:  regRdData <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_WP_BLOCK: assert property (memIf.we |-> !wpS)
    else $error("array written while protected");
  AST_WP_ALLOW: assert property (
    (ce && byteDone && phase == PH_DATA && !wpS && !stopEv && !startEv)
    |-> memIf.we ##1 (state == ST_RXACK && sdaOe))
    else $error("unprotected byte not stored and acked");
  AST_WP_DISCARD: assert property (
    (ce && byteDone && phase == PH_DATA && wpS && !startEv && !stopEv)
    |=> sdaOe && addr == $past(addr) + 14'h1)
    else $error("protected byte not acked or counted");
  AST_SEL_MATCH: assert property (
    (state == ST_RXACK && phase == PH_DEV)
    |-> shift[3:1] == strapS && shift[7:4] == DEV_TYPE)
    else $error("acked an address that is not ours");
  AST_DRIVE_ON_FALL: assert property ($changed(sdaOe)
    |-> $past(sclFall) || $past(startEv) || $past(stopEv))
    else $error("sda drive changed off a scl fall");
  AST_DRIVE_STATE: assert property (sdaOe
    |-> state inside {ST_RXACK, ST_TX} && sdaOut == 1'b0)
    else $error("sda pulled outside ack or read byte");
  AST_ADDR_WRAP: assert property (
    (ce && addrInc && !addrLoad && !startEv && !stopEv
     && addr == ADDR_LAST) |=> addr == ADDR_FIRST)
    else $error("address did not wrap to zero");
  AST_HS_STOP: assert property ((ce && stopEv)
    |=> !hsMode ##1 (state == ST_IDLE || !hsMode))
    else $error("high speed kept past stop");
  AST_START_RESET: assert property ((ce && startEv)
    |=> state == ST_RX && bitCnt == 4'h0 && phase == PH_DEV && !sdaOe)
    else $error("start did not reset byte reception");
  AST_ID_READ: assert property ((ce && regRd && regAddr == OFS_ID)
    |=> regRdData == idValue ##1 idValue == $past(idValue))
    else $error("identification value wrong or changed");
endmodule // nvm_i2c_slave
`default_nettype wire

// ---- hdl/nvm_sync.sv ----
// two-flop synchroniser for pins from outside the mclk domain
// assumes: ce freezes the stages; reset value is a parameter
`default_nettype none
module nvm_sync
  import nvm_pkg::*;
#(
  parameter int          W   = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= RV;
      dout   <= RV;
    end else if (ce) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // nvm_sync
`default_nettype wire

// ---- pkg/nvm_mem_if.sv ----
// byte port between the bus engine and the storage array
// assumes: single clock mclk; read data are combinational
`default_nettype none
interface nvm_mem_if;
  import nvm_pkg::*;
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl  (output we, output addr, output wdata, input rdata);
  modport array (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- pkg/nvm_pkg.sv ----
// constants and types for the two-wire nonvolatile memory slave
// assumes: included before every other file of the block
`default_nettype none
package nvm_pkg;
  localparam int              ADDR_W     = 14;
  localparam int              MEM_DEPTH  = 16384;
  localparam int              DATA_W     = 8;
  localparam logic [3:0]      DEV_TYPE   = 4'ha;
  localparam logic [4:0]      MCODE_HS   = 5'h01;
  localparam logic [13:0]     ADDR_LAST  = 14'h3fff;
  localparam logic [13:0]     ADDR_FIRST = 14'h0000;
  localparam logic [3:0]      BYTE_BITS  = 4'h8;
  // bus clock rates the slave must follow, in hertz
  localparam int              SCL_STD_HZ = 100_000;
  localparam int              SCL_FST_HZ = 400_000;
  localparam int              SCL_HS_HZ  = 3_400_000;
  // register port offsets and fields
  localparam logic [3:0]      OFS_ID     = 4'h0;
  localparam logic [3:0]      OFS_CTRL   = 4'h4;
  localparam logic [3:0]      OFS_STAT   = 4'h8;
  localparam int              CTRL_EN    = 0;
  localparam logic            CTRL_EN_RV = 1'b1;
  localparam int              STAT_HS    = 0;
  localparam int              STAT_BUSY  = 1;
  localparam int              STAT_WP    = 2;
  localparam int              STAT_SEL   = 4;
  // identification fields; values are arbitrary
  localparam logic [15:0]     ID_MFR     = 16'h0a5a;
  localparam logic [7:0]      ID_DENS    = 8'h01;
  localparam logic [7:0]      ID_REV     = 8'h01;

  typedef enum logic [1:0] {
    PH_DEV  = 2'h0,
    PH_HI   = 2'h1,
    PH_LO   = 2'h2,
    PH_DATA = 2'h3
  } nvm_phase_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_RXACK = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } nvm_state_t;
endpackage
`default_nettype wire

// ---- test/nvm_i2c_slave_test.sv ----
// self-checking bench for the two-wire memory slave
// assumes: master model on the link, register port driven here
`default_nettype none
module nvm_i2c_slave_test
  import nvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk;
  logic        rst;
  logic        ce;
  logic        scl;
  logic        sdaDrv;
  logic        sdaWire;
  logic        sdaOut;
  logic        sdaOe;
  logic [2:0]  straps;
  logic        wp;
  logic [3:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        hsMode;
  logic [31:0] d;
  logic [7:0]  pat [3] = '{8'h11, 8'h22, 8'h33};
  int          errors;
  int          checksDone;

  // open drain with pull-up
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);

  nvm_i2c_slave nvm_i2c_slave_i (
    .mclk(mclk), .rst(rst), .ce(ce), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceSelectStraps(straps),
    .wp(wp), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .hsMode(hsMode)
  );

  nvm_master_model nvm_master_model_i (
    .mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv)
  );

  always #50 mclk = ~mclk;

  task automatic summarize();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    v = regRdData;
  endtask

  function automatic logic [7:0] dev(input logic [2:0] s,
                                     input logic rd);
    return {DEV_TYPE, s, rd};
  endfunction

  task automatic tx(input logic [7:0] v, input logic expAck);
    logic a;
    nvm_master_model_i.send_byte(v, a);
    chk(32'(a), 32'(expAck), "ack");
  endtask

  task automatic rx(input logic last, input logic [7:0] exp);
    logic [7:0] v;
    nvm_master_model_i.recv_byte(last, v);
    chk(32'(v), 32'(exp), "read byte");
  endtask

  // start, device write, two address bytes
  task automatic set_ptr(input logic [2:0] s, input logic [7:0] hi,
                         input logic [7:0] lo);
    nvm_master_model_i.start_c();
    tx(dev(s, 1'b0), 1'b1);
    tx(hi, 1'b1);
    tx(lo, 1'b1);
  endtask

  task automatic rd_cur(input int n, input int first);
    nvm_master_model_i.start_c();
    tx(dev(straps, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      rx(i == n - 1, pat[(first + i) % 3]);
    end
    nvm_master_model_i.stop_c();
  endtask

  // look between edges, where the enable has settled
  always @(negedge mclk) begin
    if (!rst && sdaOe === 1'b1)
      chk(32'(sdaOut), 32'h0, "drive level");
  end

  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    summarize();
  end

  initial begin
    logic r;
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    straps = 3'h5;
    wp = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    errors = 0;
    checksDone = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(hsMode), 32'h0, "hs after reset");
    reg_rd(OFS_ID, d);
    chk(d, {ID_MFR, ID_DENS, ID_REV}, "id");
    reg_wr(OFS_ID, 32'h0);
    reg_rd(OFS_ID, d);
    chk(d, {ID_MFR, ID_DENS, ID_REV}, "id kept");
    reg_rd(4'hc, d);
    chk(d, 32'h0, "unmapped");
    reg_rd(OFS_STAT, d);
    chk(32'(d[6:4]), 32'h5, "straps seen");
    // a frozen clock enable drops a write; a disabled device stays silent
    @(posedge mclk);
    ce <= 1'b0;
    reg_wr(OFS_CTRL, 32'h0);
    ce <= 1'b1;
    reg_rd(OFS_CTRL, d);
    chk(d, 32'h1, "ctrl frozen");
    reg_wr(OFS_CTRL, 32'h0);
    nvm_master_model_i.start_c();
    tx(dev(3'h5, 1'b0), 1'b0);
    nvm_master_model_i.stop_c();
    reg_wr(OFS_CTRL, 32'h1);
    reg_rd(OFS_CTRL, d);
    chk(d, 32'h1, "ctrl enabled");
    // three bytes across the top of the array, wrapping
    set_ptr(3'h5, 8'hff, 8'hfe);
    for (int i = 0; i < 3; i++) tx(pat[i], 1'b1);
    nvm_master_model_i.stop_c();
    set_ptr(3'h5, 8'h7f, 8'hfe);
    rd_cur(3, 0);
    // protected writes are acked, counted and dropped
    wp <= 1'b1;
    set_ptr(3'h5, 8'h3f, 8'hfe);
    tx(8'h99, 1'b1);
    tx(8'h98, 1'b1);
    reg_rd(OFS_STAT, d);
    chk(32'(d[2:1]), 32'h3, "wp and busy seen");
    nvm_master_model_i.stop_c();
    wp <= 1'b0;
    rd_cur(1, 2);
    set_ptr(3'h5, 8'h3f, 8'hfe);
    rd_cur(2, 0);
    // other select value and other device type are ignored
    nvm_master_model_i.start_c();
    tx(dev(3'h2, 1'b0), 1'b0);
    nvm_master_model_i.start_c();
    tx(8'hba, 1'b0);
    // partial byte abandoned by a new start
    nvm_master_model_i.start_c();
    for (int i = 0; i < 3; i++) nvm_master_model_i.bitx(1'b0, r);
    set_ptr(3'h5, 8'h3f, 8'hff);
    nvm_master_model_i.stop_c();
    // master code: no ack, high speed until stop
    nvm_master_model_i.start_c();
    tx(8'h0b, 1'b0);
    chk(32'(hsMode), 32'h1, "hs entered");
    reg_rd(OFS_STAT, d);
    chk(32'(d[1:0]), 32'h1, "hs status");
    set_ptr(3'h5, 8'h3f, 8'hff);
    rd_cur(1, 1);
    nvm_master_model_i.tick(6);
    chk(32'(hsMode), 32'h0, "hs left");
    // low straps, as when left open
    straps <= 3'h0;
    set_ptr(3'h0, 8'h3f, 8'hff);
    nvm_master_model_i.stop_c();
    summarize();
  end
endmodule  // nvm_i2c_slave_test
`default_nettype wire

// ---- test/nvm_master_model.sv ----
// two-wire bus master model for the memory slave
// assumes: bench resolves sda from sdaDrv and the slave's enable;
// one bit period is eight mclk cycles, 800 ns at 10 MHz
`default_nettype none
module nvm_master_model
  import nvm_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // sda falls while scl high; also serves as repeated start
  task automatic start_c();
    tick(1);
    sdaDrv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaDrv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask

  // sda rises while scl high; the clock then stands still
  task automatic stop_c();
    tick(1);
    sdaDrv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaDrv <= 1'b1;
    tick(4);
  endtask

  // data set up late in the low, one tick before scl rises, sampled mid-high; 1 means released
  task automatic bitx(input logic b, output logic r);
    tick(3);
    sdaDrv <= b;
    tick(1);
    scl <= 1'b1;
    tick(2);
    r = sdaWire;
    tick(2);
    scl <= 1'b0;
  endtask

  // msb first, then the slave's acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // last byte of a read gets no acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(last, r);
  endtask
endmodule  // nvm_master_model
`default_nettype wire
